/* File: verilog/touch_pkg.sv */
package touch_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_COORD = 8'h0C;
  localparam logic [7:0] ADDR_REPLY = 8'h10;
  localparam int CMD_ARG_LSB = 8;
  localparam int CFG_DELTA_LSB = 0;
  localparam int CFG_FOCUS_LSB = 8;
  localparam int ST_STANDBY = 0;
  localparam int ST_SPD = 1;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_SHIFT_LSB = 8;
  localparam int ST_PWR_LSB = 12;
  localparam int COORD_Y_LSB = 16;
  localparam int REPLY_VALID = 8;

  // ==========================================================================
  // Host commands and replies
  localparam logic [7:0] OP_SPD_TOGGLE = 8'hA2;
  localparam logic [7:0] OP_WAKE = 8'hA7;
  localparam logic [7:0] OP_STANDBY = 8'hA8;
  localparam logic [7:0] OP_SET_SAMPLES = 8'hBA;
  localparam logic [7:0] OP_SET_MODE = 8'hBB;
  localparam logic [7:0] REPLY_ACK = 8'hCA;

  // ==========================================================================
  // Reset values and limits
  localparam logic RST_SPD_EN = 1'b1;
  localparam logic [2:0] RST_SHIFT = 3'h3;
  localparam logic [2:0] MAX_SHIFT = 3'h5;
  localparam logic [5:0] RST_MAX_DELTA = 6'h08;
  localparam logic [5:0] RST_FOCUS = 6'h04;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 20000000;
  localparam int IDLE_TIME_MS = 50;
  localparam int IDLE_CYCLES_DFLT = IDLE_TIME_MS * (CLK_HZ / 1000);

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    MODE_STREAM = 3'b001,
    MODE_TOUCHDOWN = 3'b010,
    MODE_LIFTOFF = 3'b100
  } mode_e;

  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_SELF = 2'b01,
    PWR_CMD = 2'b10,
    PWR_PIN = 2'b11
  } pwr_e;

  typedef struct packed {
    logic [9:0] z;
    logic [9:0] y;
    logic [9:0] x;
  } sample_s;

endpackage : touch_pkg

/* File: verilog/touch_filter_power.sv */
`timescale 1ns/1ns
`default_nettype none

// ============================================================================
// One accumulator lane of the oversampling averager.
module avg_lane
  import touch_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic clr,
  input wire logic en,
  input wire logic last,
  input wire logic [2:0] shift,
  input wire logic [9:0] sample,
  output logic [9:0] mean
);
  logic [14:0] acc_ff;
  logic [14:0] sum;

  always_comb begin
    sum = acc_ff + {5'h00, sample};
    mean = 10'(sum >> shift);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_ff <= 15'h0000;
    end else if (ce) begin
      if (clr) begin
        acc_ff <= 15'h0000;
      end else if (en) begin
        acc_ff <= last ? 15'h0000 : sum;
      end
    end
  end
endmodule : avg_lane

// ============================================================================
// Delta prediction and focus filter for one axis.
module axis_filter
  import touch_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic clr,
  input wire logic in_valid,
  input wire logic commit,
  input wire logic [9:0] in_val,
  input wire logic [5:0] max_delta,
  input wire logic [5:0] focus,
  output logic delta_ok,
  output logic [9:0] out_val
);
  logic [9:0] p1_ff;
  logic [9:0] p2_ff;
  logic [9:0] keep_ff;
  logic keep_vld_ff;
  logic [1:0] fill_ff;
  logic signed [12:0] pred;
  logic signed [12:0] err;
  logic [12:0] err_abs;
  logic [9:0] jit_abs;

  always_comb begin
    pred = $signed({2'b00, p1_ff, 1'b0}) - $signed({3'b000, p2_ff});
    err = $signed({3'b000, in_val}) - pred;
    err_abs = err[12] ? (~err + 13'h0001) : err;
    // Until two coordinates are known there is nothing to predict from.
    delta_ok = (fill_ff != 2'b10) || (err_abs <= {7'h00, max_delta});
    jit_abs = (in_val >= keep_ff) ? (in_val - keep_ff) : (keep_ff - in_val);
    if (focus == 6'h00 || !keep_vld_ff) begin
      out_val = in_val;
    end else if (jit_abs >= {4'h0, focus}) begin
      out_val = in_val;
    end else begin
      out_val = keep_ff;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      p1_ff <= 10'h000;
      p2_ff <= 10'h000;
      fill_ff <= 2'b00;
    end else if (ce) begin
      if (clr) begin
        fill_ff <= 2'b00;
      end else if (in_valid) begin
        p2_ff <= p1_ff;
        p1_ff <= in_val;
        if (fill_ff != 2'b10) begin
          fill_ff <= fill_ff + 2'b01;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      keep_ff <= 10'h000;
      keep_vld_ff <= 1'b0;
    end else if (ce) begin
      if (clr) begin
        keep_vld_ff <= 1'b0;
      end else if (commit && out_val == in_val) begin
        keep_ff <= in_val;
        keep_vld_ff <= 1'b1;
      end
    end
  end
endmodule : axis_filter

// ============================================================================
// Top: averaging, filtering, report modes, power save, APB registers.
module touch_filter_power
  import touch_pkg::*;
#(
  parameter int IDLE_CYCLES = IDLE_CYCLES_DFLT
) (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SHUTDOWN_N,
  input wire logic TOUCH,
  input wire logic RX_ACTIVE,
  input wire logic ADC_VALID,
  input wire sample_s ADC_SAMPLE,
  output logic RPT_VALID,
  output sample_s RPT_COORD,
  output logic LED,
  output logic OSC_EN,
  output logic UART_FLUSH,
  output logic STANDBY
);
  pwr_e pwr_ff;
  pwr_e nxt_pwr;
  mode_e mode_ff;
  logic spd_en_ff;
  logic [2:0] shift_ff;
  logic [5:0] max_delta_ff;
  logic [5:0] focus_ff;
  logic [15:0] cmd_ff;
  logic cmd_stb_ff;
  logic [8:0] reply_ff;
  logic [23:0] idle_ff;
  logic [4:0] cnt_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic avg_valid_ff;
  sample_s avg_ff;
  sample_s avg_mean;
  logic flt_valid_ff;
  sample_s flt_ff;
  sample_s held_ff;
  logic held_vld_ff;
  logic sent_ff;
  logic touch_q_ff;
  logic rpt_valid_ff;
  sample_s rpt_ff;
  logic led_ff;
  logic osc_en_ff;
  logic flush_ff;
  logic standby_ff;
  logic acc_x;
  logic acc_y;
  logic [9:0] fx;
  logic [9:0] fy;
  logic run;
  logic clr_pipe;
  logic wake_flush;
  logic last;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic [7:0] op;
  logic [7:0] arg;
  logic reply_set;

  localparam logic [23:0] IDLE_LIMIT = 24'(IDLE_CYCLES - 1);

  // ==========================================================================
  // APB slave
  assign wr_acc = PSEL && PENABLE && pready_ff && PWRITE;
  assign rd_acc = PSEL && PENABLE && pready_ff && !PWRITE;
  assign mapped = PADDR == ADDR_CMD || PADDR == ADDR_CFG || PADDR == ADDR_STATUS ||
                  PADDR == ADDR_COORD || PADDR == ADDR_REPLY;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else if (CE) begin
      // One wait-free access phase: data is prepared during the setup cycle.
      pready_ff <= PSEL && !PENABLE && !pready_ff;
      pslverr_ff <= PSEL && !PENABLE && !mapped;
      prdata_ff <= 32'h00000000;
      if (PSEL && !PENABLE && !PWRITE) begin
        unique case (PADDR)
          ADDR_CMD: prdata_ff <= {16'h0000, cmd_ff};
          ADDR_CFG: prdata_ff <= {18'h00000, focus_ff, 2'b00, max_delta_ff};
          ADDR_STATUS: prdata_ff <= {18'h00000, pwr_ff, 1'b0, shift_ff, 1'b0, mode_ff,
                                     2'b00, spd_en_ff, standby_ff};
          ADDR_COORD: prdata_ff <= {6'h00, rpt_ff.y, 6'h00, rpt_ff.x};
          ADDR_REPLY: prdata_ff <= {23'h000000, reply_ff};
          default: prdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cmd_ff <= 16'h0000;
      cmd_stb_ff <= 1'b0;
      max_delta_ff <= RST_MAX_DELTA;
      focus_ff <= RST_FOCUS;
    end else if (CE) begin
      cmd_stb_ff <= 1'b0;
      if (wr_acc && PADDR == ADDR_CMD) begin
        cmd_ff <= PWDATA[15:0];
        cmd_stb_ff <= 1'b1;
      end
      if (wr_acc && PADDR == ADDR_CFG) begin
        max_delta_ff <= PWDATA[CFG_DELTA_LSB +: 6];
        focus_ff <= PWDATA[CFG_FOCUS_LSB +: 6];
      end
    end
  end

  // ==========================================================================
  // Command execution
  assign op = cmd_ff[7:0];
  assign arg = cmd_ff[CMD_ARG_LSB +: 8];
  assign run = pwr_ff == PWR_RUN;
  // Outside run state only the wake command is decoded.
  assign reply_set = cmd_stb_ff && run && op != OP_WAKE;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      spd_en_ff <= RST_SPD_EN;
      mode_ff <= MODE_STREAM;
      shift_ff <= RST_SHIFT;
    end else if (CE) begin
      if (cmd_stb_ff && run) begin
        if (op == OP_SPD_TOGGLE) begin
          spd_en_ff <= !spd_en_ff;
        end
        if (op == OP_SET_MODE) begin
          unique case (arg)
            8'h01: mode_ff <= MODE_STREAM;
            8'h02: mode_ff <= MODE_TOUCHDOWN;
            8'h04: mode_ff <= MODE_LIFTOFF;
            default: mode_ff <= mode_ff;
          endcase
        end
        if (op == OP_SET_SAMPLES) begin
          unique case (arg)
            8'h01: shift_ff <= 3'h0;
            8'h02: shift_ff <= 3'h1;
            8'h04: shift_ff <= 3'h2;
            8'h08: shift_ff <= 3'h3;
            8'h10: shift_ff <= 3'h4;
            8'h20: shift_ff <= MAX_SHIFT;
            default: shift_ff <= shift_ff;
          endcase
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      reply_ff <= 9'h000;
    end else if (CE) begin
      // A new reply beats a read-clear or a flush in the same cycle.
      if (reply_set) begin
        reply_ff <= {1'b1, REPLY_ACK};
      end else if ((rd_acc && PADDR == ADDR_REPLY) || wake_flush) begin
        reply_ff <= 9'h000;
      end
    end
  end

  // ==========================================================================
  // Power save state machine
  always_comb begin
    nxt_pwr = pwr_ff;
    wake_flush = 1'b0;
    if (!SHUTDOWN_N) begin
      nxt_pwr = PWR_PIN;
    end else begin
      unique case (pwr_ff)
        PWR_RUN: begin
          if (cmd_stb_ff && op == OP_STANDBY) begin
            nxt_pwr = PWR_CMD;
          end else if (spd_en_ff && idle_ff == IDLE_LIMIT) begin
            nxt_pwr = PWR_SELF;
          end
        end
        PWR_SELF: begin
          if (TOUCH || RX_ACTIVE || cmd_stb_ff) begin
            nxt_pwr = PWR_RUN;
          end
        end
        PWR_CMD: begin
          if ((cmd_stb_ff && op == OP_WAKE) || (spd_en_ff && TOUCH)) begin
            nxt_pwr = PWR_RUN;
            wake_flush = 1'b1;
          end
        end
        PWR_PIN: begin
          nxt_pwr = PWR_RUN;
          wake_flush = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pwr_ff <= PWR_RUN;
      idle_ff <= 24'h000000;
    end else if (CE) begin
      pwr_ff <= nxt_pwr;
      if (!run || TOUCH || RX_ACTIVE || cmd_stb_ff || (PSEL && PENABLE)) begin
        idle_ff <= 24'h000000;
      end else if (idle_ff != IDLE_LIMIT) begin
        idle_ff <= idle_ff + 24'h000001;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      led_ff <= 1'b0;
      osc_en_ff <= 1'b1;
      standby_ff <= 1'b0;
      flush_ff <= 1'b0;
    end else if (CE) begin
      led_ff <= nxt_pwr != PWR_RUN;
      osc_en_ff <= nxt_pwr == PWR_RUN;
      standby_ff <= nxt_pwr != PWR_RUN;
      flush_ff <= wake_flush;
    end
  end

  // ==========================================================================
  // Oversampling averager
  // Standby drops any half-built average so a stale partial sum cannot leak out.
  assign clr_pipe = !run || wake_flush;
  assign last = cnt_ff == 5'((6'h01 << shift_ff) - 6'h01);

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_ff <= 5'h00;
    end else if (CE) begin
      if (clr_pipe) begin
        cnt_ff <= 5'h00;
      end else if (ADC_VALID) begin
        cnt_ff <= last ? 5'h00 : cnt_ff + 5'h01;
      end
    end
  end

  avg_lane u_avg_x (.clk(SYS_CLK), .arst_n(ARST_N), .ce(CE), .clr(clr_pipe),
    .en(ADC_VALID), .last(last), .shift(shift_ff), .sample(ADC_SAMPLE.x),
    .mean(avg_mean.x));
  avg_lane u_avg_y (.clk(SYS_CLK), .arst_n(ARST_N), .ce(CE), .clr(clr_pipe),
    .en(ADC_VALID), .last(last), .shift(shift_ff), .sample(ADC_SAMPLE.y),
    .mean(avg_mean.y));
  avg_lane u_avg_z (.clk(SYS_CLK), .arst_n(ARST_N), .ce(CE), .clr(clr_pipe),
    .en(ADC_VALID), .last(last), .shift(shift_ff), .sample(ADC_SAMPLE.z),
    .mean(avg_mean.z));

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      avg_valid_ff <= 1'b0;
      avg_ff <= '0;
    end else if (CE) begin
      avg_valid_ff <= !clr_pipe && ADC_VALID && last;
      if (!clr_pipe && ADC_VALID && last) begin
        avg_ff <= avg_mean;
      end
    end
  end

  // ==========================================================================
  // Delta and focus filters
  axis_filter u_flt_x (.clk(SYS_CLK), .arst_n(ARST_N), .ce(CE), .clr(clr_pipe),
    .in_valid(avg_valid_ff), .commit(avg_valid_ff && acc_x && acc_y),
    .in_val(avg_ff.x), .max_delta(max_delta_ff), .focus(focus_ff),
    .delta_ok(acc_x), .out_val(fx));
  axis_filter u_flt_y (.clk(SYS_CLK), .arst_n(ARST_N), .ce(CE), .clr(clr_pipe),
    .in_valid(avg_valid_ff), .commit(avg_valid_ff && acc_x && acc_y),
    .in_val(avg_ff.y), .max_delta(max_delta_ff), .focus(focus_ff),
    .delta_ok(acc_y), .out_val(fy));

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flt_valid_ff <= 1'b0;
      flt_ff <= '0;
    end else if (CE) begin
      flt_valid_ff <= avg_valid_ff && acc_x && acc_y && !clr_pipe;
      if (avg_valid_ff && acc_x && acc_y) begin
        flt_ff <= '{z: avg_ff.z, y: fy, x: fx};
      end
    end
  end

  // ==========================================================================
  // Report modes
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      touch_q_ff <= 1'b0;
      sent_ff <= 1'b0;
      held_vld_ff <= 1'b0;
      held_ff <= '0;
      rpt_valid_ff <= 1'b0;
      rpt_ff <= '0;
    end else if (CE) begin
      touch_q_ff <= TOUCH && run;
      rpt_valid_ff <= 1'b0;
      if (!TOUCH || clr_pipe) begin
        sent_ff <= 1'b0;
      end
      if (clr_pipe) begin
        held_vld_ff <= 1'b0;
      end else begin
        unique case (mode_ff)
          MODE_STREAM: begin
            if (flt_valid_ff && TOUCH) begin
              rpt_valid_ff <= 1'b1;
              rpt_ff <= flt_ff;
            end
          end
          MODE_TOUCHDOWN: begin
            if (flt_valid_ff && TOUCH && !sent_ff) begin
              rpt_valid_ff <= 1'b1;
              rpt_ff <= flt_ff;
              sent_ff <= 1'b1;
            end
          end
          MODE_LIFTOFF: begin
            if (flt_valid_ff && TOUCH) begin
              held_ff <= flt_ff;
              held_vld_ff <= 1'b1;
            end else if (touch_q_ff && !TOUCH && held_vld_ff) begin
              rpt_valid_ff <= 1'b1;
              rpt_ff <= held_ff;
              held_vld_ff <= 1'b0;
            end
          end
          default: rpt_valid_ff <= 1'b0;
        endcase
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign RPT_VALID = rpt_valid_ff;
  assign RPT_COORD = rpt_ff;
  assign LED = led_ff;
  assign OSC_EN = osc_en_ff;
  assign UART_FLUSH = flush_ff;
  assign STANDBY = standby_ff;

endmodule : touch_filter_power

`default_nettype wire

/* File: testbench/touch_checker_assertions.sv */
`timescale 1ns/1ns
`default_nettype none

// ========================================
// Power, report and APB checks at the top-level pins.
module touch_checker #(
  parameter int IDLE_CYCLES = 20
) (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SHUTDOWN_N,
  input wire logic TOUCH,
  input wire logic RPT_VALID,
  input wire logic LED,
  input wire logic OSC_EN,
  input wire logic UART_FLUSH,
  input wire logic STANDBY
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!ARST_N);

  a_standby_led: assert property (STANDBY |-> LED && !OSC_EN)
    else $error("standby without led high and oscillator off");
  a_osc_stop: assert property ($fell(OSC_EN) |-> STANDBY)
    else $error("oscillator stopped outside standby");
  a_standby_quiet: assert property (STANDBY [*4] |-> !RPT_VALID)
    else $error("report sent during standby");
  a_pin_holds: assert property (!SHUTDOWN_N && CE |=> STANDBY)
    else $error("shutdown pin low but not in standby");
  a_pin_flush: assert property ($rose(SHUTDOWN_N) && STANDBY |-> ##[1:2] UART_FLUSH)
    else $error("no buffer flush after shutdown release");
  a_flush_single: assert property (UART_FLUSH |=> !UART_FLUSH)
    else $error("flush pulse longer than one cycle");
  a_flush_cause: assert property ($rose(UART_FLUSH) |-> $past(STANDBY) || $past(STANDBY, 2))
    else $error("flush without leaving standby");
  a_rpt_touch: assert property (RPT_VALID |-> $past(TOUCH) || $past(TOUCH, 2))
    else $error("report without a touch");
  a_apb_ready: assert property (PSEL && !PENABLE && CE |=> PREADY)
    else $error("no ready after setup cycle");
  a_slverr_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
    else $error("slave error outside access phase");

  c_flush: cover property (UART_FLUSH);
  c_report: cover property (RPT_VALID);
  c_wake: cover property ($fell(STANDBY));
  c_error: cover property (PSLVERR);
endmodule : touch_checker

bind touch_filter_power touch_checker #(.IDLE_CYCLES(IDLE_CYCLES)) u_checker (
  .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .SHUTDOWN_N(SHUTDOWN_N), .TOUCH(TOUCH),
  .RPT_VALID(RPT_VALID), .LED(LED), .OSC_EN(OSC_EN), .UART_FLUSH(UART_FLUSH),
  .STANDBY(STANDBY)
);

`default_nettype wire

/* File: testbench/panel_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ========================================
// Panel and converter stand-in: one burst of raw samples per request.
module panel_model
  import touch_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic [5:0] count,
  input wire sample_s value,
  output logic adc_valid,
  output sample_s adc_sample
);
  logic [5:0] left_ff = 6'h00;
  logic [9:0] junk_ff = 10'h000;
  logic [9:0] step;

  always @(posedge clk) begin
    junk_ff <= junk_ff + 10'h001;
    if (go) begin
      left_ff <= count;
    end else if (left_ff != 6'h00) begin
      left_ff <= left_ff - 6'h01;
    end
  end

  // Samples carry a falling offset so that a wrong divisor shows in the mean.
  // Between bursts the lines move every cycle instead of holding the last sample.
  assign adc_valid = (left_ff != 6'h00);
  assign step = adc_valid ? {4'h0, left_ff} : junk_ff;
  assign adc_sample = {value.z + step, value.y + step, value.x + step};
endmodule : panel_model

`default_nettype wire

/* File: testbench/touch_filter_power_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module touch_filter_power_tb
  import touch_pkg::*;
;
  localparam int IDLE = 20;
  // The host pauses one millisecond of 50 ns cycles after a wake, for the oscillator restart.
  localparam int WAKE_WAIT = 20000;
  localparam sample_s BASE = {10'h080, 10'h200, 10'h100};
  logic clk, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic arst_n = 1'b0, shut_n = 1'b1, touch = 1'b0, rx_act = 1'b0, go = 1'b0;
  logic rpt_valid, led, osc_en, flush, standby, adc_valid;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [5:0] feed_n = 6'h00;
  sample_s adc_sample, rpt_coord, last_coord, feed_val = BASE;
  int err_count = 0, check_count = 0, rpt_cnt, flush_cnt, n;

  touch_filter_power #(.IDLE_CYCLES(IDLE)) dut (
    .SYS_CLK(clk), .ARST_N(arst_n), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SHUTDOWN_N(shut_n), .TOUCH(touch), .RX_ACTIVE(rx_act),
    .ADC_VALID(adc_valid), .ADC_SAMPLE(adc_sample), .RPT_VALID(rpt_valid),
    .RPT_COORD(rpt_coord), .LED(led), .OSC_EN(osc_en), .UART_FLUSH(flush), .STANDBY(standby)
  );
  panel_model u_panel (.clk(clk), .go(go), .count(feed_n), .value(feed_val),
    .adc_valid(adc_valid), .adc_sample(adc_sample));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ========================================
  // Access and checking tasks
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      complete_run();
    end
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rd_chk

  task automatic cmd(input logic [7:0] op, input logic [7:0] arg);
    apb(1'b1, ADDR_CMD, {16'h0000, arg, op});
  endtask : cmd

  task automatic watch(input int cyc);
    rpt_cnt = 0;
    flush_cnt = 0;
    repeat (cyc) begin
      @(posedge clk);
      if (rpt_valid === 1'b1) begin
        rpt_cnt++;
        last_coord = rpt_coord;
      end
      if (flush === 1'b1) flush_cnt++;
    end
  endtask : watch

  function automatic sample_s plus(input sample_s v, input logic [9:0] d);
    return {v.z + d, v.y + d, v.x + d};
  endfunction : plus

  task automatic feed(input logic [5:0] cnt, input sample_s v);
    @(posedge clk);
    go <= 1'b1;
    feed_n <= cnt;
    feed_val <= v;
    @(posedge clk);
    go <= 1'b0;
    watch(int'(cnt) + 12);
  endtask : feed

  // Only x and y are compared: z skips the focus filter.
  task automatic expect_rpt(input int cnt, input logic [9:0] d);
    sample_s e;
    e = plus(BASE, d);
    check(rpt_cnt, cnt);
    if (cnt > 0) check({12'h000, last_coord.y, last_coord.x}, {12'h000, e.y, e.x});
  endtask : expect_rpt

  initial begin
    #(50 * 60000);
    err_count++;
    complete_run();
  end

  // ========================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(ADDR_STATUS, 32'h0000_0312);
    rd_chk(ADDR_CFG, 32'h0000_0408);
    apb(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
    rd_chk(ADDR_STATUS, 32'h0000_0312);
    rd_chk(8'h14, 32'h0);
    check(err, 1'b1);
    cmd(OP_SPD_TOGGLE, 8'h00);
    rd_chk(ADDR_STATUS, 32'h0000_0310);
    rd_chk(ADDR_REPLY, 32'h0000_01CA);
    rd_chk(ADDR_REPLY, 32'h0);
    apb(1'b1, ADDR_CFG, 32'h0000_003F);
    touch <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      n = 1 << i;
      cmd(OP_SET_SAMPLES, 8'(n));
      rd_chk(ADDR_STATUS, 32'h10 | (i << 8));
      feed(6'(n), BASE);
      expect_rpt(1, 10'((n * (n + 1) / 2) >> i));
    end
    rd_chk(ADDR_COORD, 32'h0210_0110);
    // Primers leave the history at +8 then +16 whether or not it was cleared.
    apb(1'b1, ADDR_CFG, 32'h0000_0016);
    cmd(OP_SET_SAMPLES, 8'h01);
    feed(6'h01, plus(BASE, 10'h007));
    feed(6'h01, plus(BASE, 10'h00F));
    feed(6'h01, BASE);
    expect_rpt(0, 10'h000);
    feed(6'h01, BASE);
    expect_rpt(1, 10'h001);
    apb(1'b1, ADDR_CFG, 32'h0000_043F);
    feed(6'h01, BASE);
    feed(6'h01, plus(BASE, 10'h002));
    expect_rpt(1, 10'h001);
    feed(6'h01, plus(BASE, 10'h004));
    expect_rpt(1, 10'h005);
    apb(1'b1, ADDR_CFG, 32'h0000_003F);
    cmd(OP_SET_MODE, 8'h02);
    rd_chk(ADDR_STATUS, 32'h0000_0020);
    touch <= 1'b0;
    watch(3);
    touch <= 1'b1;
    feed(6'h01, plus(BASE, 10'h005));
    expect_rpt(1, 10'h006);
    feed(6'h01, plus(BASE, 10'h006));
    expect_rpt(0, 10'h000);
    cmd(OP_SET_MODE, 8'h04);
    rd_chk(ADDR_STATUS, 32'h0000_0040);
    feed(6'h01, plus(BASE, 10'h007));
    expect_rpt(0, 10'h000);
    touch <= 1'b0;
    watch(6);
    expect_rpt(1, 10'h008);
    cmd(OP_SET_MODE, 8'h03);
    cmd(OP_SET_MODE, 8'h01);
    rd_chk(ADDR_STATUS, 32'h0000_0010);
    cmd(OP_STANDBY, 8'h00);
    rd_chk(ADDR_STATUS, 32'h0000_2011);
    check({led, osc_en}, 2'b10);
    rd_chk(ADDR_REPLY, 32'h0000_01CA);
    touch <= 1'b1;
    feed(6'h01, BASE);
    expect_rpt(0, 10'h000);
    check(standby, 1'b1);
    cmd(OP_WAKE, 8'h00);
    watch(WAKE_WAIT);
    check({flush_cnt[1:0], standby}, 3'b010);
    rd_chk(ADDR_REPLY, 32'h0);
    cmd(OP_SPD_TOGGLE, 8'h00);
    cmd(OP_STANDBY, 8'h00);
    touch <= 1'b0;
    watch(3);
    touch <= 1'b1;
    watch(WAKE_WAIT);
    check({flush_cnt[1:0], standby}, 3'b010);
    touch <= 1'b0;
    watch(IDLE + 10);
    rd_chk(ADDR_STATUS, 32'h0000_1013);
    rx_act <= 1'b1;
    watch(4);
    check({flush_cnt[1:0], standby}, 3'b000);
    rx_act <= 1'b0;
    watch(IDLE - 4);
    check(standby, 1'b0);
    watch(14);
    check(standby, 1'b1);
    touch <= 1'b1;
    watch(4);
    check(standby, 1'b0);
    shut_n <= 1'b0;
    rx_act <= 1'b1;
    watch(3);
    check({led, standby}, 2'b11);
    cmd(OP_WAKE, 8'h00);
    feed(6'h01, BASE);
    expect_rpt(0, 10'h000);
    check(standby, 1'b1);
    rx_act <= 1'b0;
    shut_n <= 1'b1;
    watch(4);
    check({flush_cnt[1:0], standby}, 3'b010);
    feed(6'h01, BASE);
    expect_rpt(1, 10'h001);
    complete_run();
  end
endmodule : touch_filter_power_tb

`default_nettype wire
